// *** smc_pkg.sv ***
/*
   Constants, state codes and timing counts of the sleep mode controller.
   Assumes a 20 MHz system clock and one chip reset.
*/
`default_nettype none
package smc_pkg;
   // ----------------------------------------------------------------
   // mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_ADCNR = 3'h1;
   localparam logic [2:0] MODE_PDOWN = 3'h2;
   localparam logic [2:0] MODE_PSAVE = 3'h3;
   localparam logic [2:0] MODE_STBY = 3'h6;
   localparam logic [2:0] MODE_XSTBY = 3'h7;
   // ----------------------------------------------------------------
   // clock enable vector positions
   // ----------------------------------------------------------------
   localparam int CLK_CPU = 0;
   localparam int CLK_FLASH = 1;
   localparam int CLK_IO = 2;
   localparam int CLK_ADC = 3;
   localparam int CLK_ASY = 4;
   localparam int CLK_OSC = 5;
   localparam int CLK_TOSC = 6;
   localparam int CLK_N = 7;
   localparam logic [CLK_N-1:0] CLK_ALL_ON = 7'h7F;
   localparam logic [CLK_N-1:0] CLK_ALL_OFF = 7'h00;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int BOD_WAKE_NS = 60000;
   localparam int BOD_WAKE_CYC = BOD_WAKE_NS / CLK_PERIOD_NS;
   localparam int STBY_WAKE_CYC = 6;
   localparam int HALT_CYC = 4;
   localparam int STARTUP_CYC = 16;
   localparam int CNT_W = 12;
   // ----------------------------------------------------------------
   // reset values and states
   // ----------------------------------------------------------------
   localparam logic BROWNOUT_SLEEP_OFF_RESET = 1'b0;
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE, ST_HALT} smc_fsm_t;
endpackage
`default_nettype wire

// *** smc_wake_if.sv ***
/*
   Wake source bundle between the controller and its wake qualifier.
   Assumes every source is a synchronous level, already enabled.
*/
`timescale 1ns/1ps
`default_nettype none
interface smc_wake_if;
   logic [2:0] mode;
   logic extIrqA, extIrqB, extLevelA, extLevelB, pinChangeIrq;
   logic twoWireMatch, timer2Irq, timer2Async, spmReady, adcDone;
   logic watchdogIrq, otherIoIrq, extReset, watchdogReset, brownoutReset;
   logic wakeIrq, wakeReset;
   modport qual (
      input mode, extIrqA, extIrqB, extLevelA, extLevelB, pinChangeIrq,
      input twoWireMatch, timer2Irq, timer2Async, spmReady, adcDone,
      input watchdogIrq, otherIoIrq, extReset, watchdogReset, brownoutReset,
      output wakeIrq, wakeReset
   );
   modport ctrl (
      output mode, extIrqA, extIrqB, extLevelA, extLevelB, pinChangeIrq,
      output twoWireMatch, timer2Irq, timer2Async, spmReady, adcDone,
      output watchdogIrq, otherIoIrq, extReset, watchdogReset, brownoutReset,
      input wakeIrq, wakeReset
   );
endinterface
`default_nettype wire

// *** smc_wake_qual.sv ***
/*
   Wake qualifier: picks the wake sources that count in the sleep mode.
   Assumes sources are synchronous levels; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_wake_qual (
   // wake bundle
   smc_wake_if.qual wk
);
   logic extLevel;
   logic t2Async;
   logic common;
   always_comb begin
      extLevel = (wk.extIrqA & wk.extLevelA) | (wk.extIrqB & wk.extLevelB);
      t2Async = wk.timer2Irq & wk.timer2Async;
      common = extLevel | wk.pinChangeIrq | wk.twoWireMatch | wk.watchdogIrq;
      wk.wakeReset = wk.extReset | wk.watchdogReset | wk.brownoutReset;
      unique case (wk.mode)
         smc_pkg::MODE_IDLE: wk.wakeIrq = wk.extIrqA | wk.extIrqB | wk.pinChangeIrq |
            wk.twoWireMatch | wk.timer2Irq | wk.spmReady | wk.adcDone |
            wk.watchdogIrq | wk.otherIoIrq;
         smc_pkg::MODE_ADCNR: wk.wakeIrq = common | t2Async | wk.spmReady | wk.adcDone;
         smc_pkg::MODE_PDOWN: wk.wakeIrq = common;
         smc_pkg::MODE_PSAVE: wk.wakeIrq = common | t2Async;
         smc_pkg::MODE_STBY: wk.wakeIrq = common;
         smc_pkg::MODE_XSTBY: wk.wakeIrq = common | t2Async;
         default: wk.wakeIrq = 1'b0;
      endcase
   end
endmodule // smc_wake_qual
`default_nettype wire

// *** smc_sleep_ctrl.sv ***
/*
   Sleep mode controller top: sleep entry, clock domain gating, wake
   timing and brown-out detector sleep control.
   Assumes the cpu core pulses sleepInstr once per sleep instruction and
   holds while cpuHalt is high; all inputs synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl #(
   parameter int STARTUP_CYCLES = smc_pkg::STARTUP_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // cpu core
   input wire logic sleepInstr,
   output logic cpuHalt,
   output logic irqResume,
   output logic resetVector,
   output logic sleepIgnored,
   output logic sleepActive,
   // sleep control register bits
   input wire logic sleepArmBit,
   input wire logic [2:0] sleepModeSelect,
   // brown-out control
   input wire logic bodFuseEnable,
   input wire logic bodsWrite,
   input wire logic bodsWrData,
   input wire logic bodsTimedEnable,
   output logic brownoutSleepOff,
   output logic brownoutEnable,
   // analog comparator
   input wire logic comparatorDisableBit,
   output logic comparatorPowerDown,
   // converter
   input wire logic adcEnabled,
   input wire logic adcDone,
   output logic adcStartConv,
   // wake sources
   input wire logic extIrqA,
   input wire logic extIrqB,
   input wire logic extLevelA,
   input wire logic extLevelB,
   input wire logic pinChangeIrq,
   input wire logic twoWireMatch,
   input wire logic timer2Irq,
   input wire logic timer2Async,
   input wire logic spmReady,
   input wire logic watchdogIrq,
   input wire logic otherIoIrq,
   input wire logic extReset,
   input wire logic watchdogReset,
   input wire logic brownoutReset,
   // clock domain enables
   output logic cpuClockEn,
   output logic flashClockEn,
   output logic ioClockEn,
   output logic converterClockEn,
   output logic asyncClockEn,
   output logic mainOscEn,
   output logic timerOscEn
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      smc_pkg::smc_fsm_t fsm;
      logic [smc_pkg::CNT_W-1:0] cnt;
      logic [2:0] mode;
      logic bodOff;
      logic resetWake;
      logic brownout_sleep_off;
      logic cpuHalt;
      logic irqResume;
      logic resetVector;
      logic sleepIgnored;
      logic sleepActive;
      logic bodEnable;
      logic compPd;
      logic adcStart;
      logic [smc_pkg::CLK_N-1:0] clkEn;
   } smc_state_t;
   smc_state_t st;
   smc_state_t next_st;

   // ----------------------------------------------------------------
   // wake qualifier
   // ----------------------------------------------------------------
   smc_wake_if wk ();
   assign wk.mode = st.mode;
   assign wk.extIrqA = extIrqA;
   assign wk.extIrqB = extIrqB;
   assign wk.extLevelA = extLevelA;
   assign wk.extLevelB = extLevelB;
   assign wk.pinChangeIrq = pinChangeIrq;
   assign wk.twoWireMatch = twoWireMatch;
   assign wk.timer2Irq = timer2Irq;
   assign wk.timer2Async = timer2Async;
   assign wk.spmReady = spmReady;
   assign wk.adcDone = adcDone;
   assign wk.watchdogIrq = watchdogIrq;
   assign wk.otherIoIrq = otherIoIrq;
   assign wk.extReset = extReset;
   assign wk.watchdogReset = watchdogReset;
   assign wk.brownoutReset = brownoutReset;
   smc_wake_qual uQual (
      .wk(wk.qual)
   );

   // ----------------------------------------------------------------
   // mode helpers
   // ----------------------------------------------------------------
   function automatic logic modeLegal(input logic [2:0] m);
      modeLegal = (m == smc_pkg::MODE_IDLE) || (m == smc_pkg::MODE_ADCNR) ||
         (m == smc_pkg::MODE_PDOWN) || (m == smc_pkg::MODE_PSAVE) ||
         (m == smc_pkg::MODE_STBY) || (m == smc_pkg::MODE_XSTBY);
   endfunction
   function automatic logic deepMode(input logic [2:0] m);
      deepMode = (m != smc_pkg::MODE_IDLE) && (m != smc_pkg::MODE_ADCNR);
   endfunction
   function automatic logic oscKept(input logic [2:0] m);
      oscKept = !deepMode(m) || (m == smc_pkg::MODE_STBY) || (m == smc_pkg::MODE_XSTBY);
   endfunction
   function automatic logic [smc_pkg::CLK_N-1:0] sleepClocks(input logic [2:0] m,
                                                               input logic async);
      logic [smc_pkg::CLK_N-1:0] c;
      c = smc_pkg::CLK_ALL_OFF;
      unique case (m)
         smc_pkg::MODE_IDLE: begin
            c = smc_pkg::CLK_ALL_ON;
            c[smc_pkg::CLK_CPU] = 1'b0;
            c[smc_pkg::CLK_FLASH] = 1'b0;
            c[smc_pkg::CLK_TOSC] = async;
         end
         smc_pkg::MODE_ADCNR: begin
            c[smc_pkg::CLK_ADC] = 1'b1;
            c[smc_pkg::CLK_OSC] = 1'b1;
            c[smc_pkg::CLK_ASY] = async;
            c[smc_pkg::CLK_TOSC] = async;
         end
         smc_pkg::MODE_PDOWN: c = smc_pkg::CLK_ALL_OFF;
         smc_pkg::MODE_PSAVE: begin
            c[smc_pkg::CLK_ASY] = async;
            c[smc_pkg::CLK_TOSC] = async;
         end
         smc_pkg::MODE_STBY: c[smc_pkg::CLK_OSC] = 1'b1;
         smc_pkg::MODE_XSTBY: begin
            c[smc_pkg::CLK_OSC] = 1'b1;
            c[smc_pkg::CLK_ASY] = async;
            c[smc_pkg::CLK_TOSC] = async;
         end
         default: c = smc_pkg::CLK_ALL_ON;
      endcase
      sleepClocks = c;
   endfunction
   function automatic logic [smc_pkg::CNT_W-1:0] wakeDelay(input logic bodWasOff,
                                                             input logic [2:0] m);
      if (bodWasOff)
         wakeDelay = smc_pkg::CNT_W'(smc_pkg::BOD_WAKE_CYC);
      else if (oscKept(m))
         wakeDelay = smc_pkg::CNT_W'(smc_pkg::STBY_WAKE_CYC);
      else
         wakeDelay = smc_pkg::CNT_W'(STARTUP_CYCLES);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.irqResume = 1'b0;
      next_st.resetVector = 1'b0;
      next_st.sleepIgnored = 1'b0;
      next_st.adcStart = 1'b0;
      if (bodsWrite && bodsTimedEnable) begin
         next_st.brownout_sleep_off = bodsWrData;
      end
      next_st.compPd = comparatorDisableBit | (st.sleepActive & deepMode(st.mode));
      unique case (st.fsm)
         smc_pkg::ST_RUN: begin
            next_st.cpuHalt = 1'b0;
            next_st.sleepActive = 1'b0;
            next_st.clkEn = smc_pkg::CLK_ALL_ON;
            next_st.bodEnable = bodFuseEnable;
            if (sleepInstr) begin
               if (sleepArmBit && modeLegal(sleepModeSelect)) begin
                  next_st.fsm = smc_pkg::ST_SLEEP;
                  next_st.mode = sleepModeSelect;
                  next_st.cpuHalt = 1'b1;
                  next_st.sleepActive = 1'b1;
                  next_st.resetWake = 1'b0;
                  next_st.clkEn = sleepClocks(sleepModeSelect, timer2Async);
                  next_st.bodOff = st.brownout_sleep_off & deepMode(sleepModeSelect);
                  next_st.bodEnable = bodFuseEnable & ~(st.brownout_sleep_off & deepMode(sleepModeSelect));
                  next_st.adcStart = (sleepModeSelect == smc_pkg::MODE_ADCNR) & adcEnabled;
               end else begin
                  next_st.sleepIgnored = 1'b1;
               end
            end
         end
         smc_pkg::ST_SLEEP: begin
            next_st.clkEn = sleepClocks(st.mode, timer2Async);
            next_st.bodEnable = bodFuseEnable & ~st.bodOff;
            if (wk.wakeReset || wk.wakeIrq) begin
               next_st.fsm = smc_pkg::ST_WAKE;
               next_st.resetWake = wk.wakeReset;
               next_st.bodEnable = bodFuseEnable;
               next_st.clkEn[smc_pkg::CLK_OSC] = 1'b1;
               next_st.cnt = wakeDelay(st.bodOff, st.mode);
            end
         end
         smc_pkg::ST_WAKE: begin
            next_st.bodEnable = bodFuseEnable;
            if (wk.wakeReset) begin
               next_st.resetWake = 1'b1;
            end
            if (st.cnt <= smc_pkg::CNT_W'(1)) begin
               next_st.clkEn = smc_pkg::CLK_ALL_ON;
               next_st.sleepActive = 1'b0;
               next_st.bodOff = 1'b0;
               if (st.resetWake || wk.wakeReset) begin
                  next_st.fsm = smc_pkg::ST_RUN;
                  next_st.cpuHalt = 1'b0;
                  next_st.resetVector = 1'b1;
               end else begin
                  next_st.fsm = smc_pkg::ST_HALT;
                  next_st.cnt = smc_pkg::CNT_W'(smc_pkg::HALT_CYC);
               end
            end else begin
               next_st.cnt = st.cnt - smc_pkg::CNT_W'(1);
            end
         end
         smc_pkg::ST_HALT: begin
            if (wk.wakeReset) begin
               next_st.fsm = smc_pkg::ST_RUN;
               next_st.cpuHalt = 1'b0;
               next_st.resetVector = 1'b1;
            end else if (st.cnt <= smc_pkg::CNT_W'(1)) begin
               next_st.fsm = smc_pkg::ST_RUN;
               next_st.cpuHalt = 1'b0;
               next_st.irqResume = 1'b1;
            end else begin
               next_st.cnt = st.cnt - smc_pkg::CNT_W'(1);
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
         st.fsm <= smc_pkg::ST_RUN;
         st.brownout_sleep_off <= smc_pkg::BROWNOUT_SLEEP_OFF_RESET;
         st.bodEnable <= 1'b1;
         st.clkEn <= smc_pkg::CLK_ALL_ON;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cpuHalt = st.cpuHalt;
   assign irqResume = st.irqResume;
   assign resetVector = st.resetVector;
   assign sleepIgnored = st.sleepIgnored;
   assign sleepActive = st.sleepActive;
   assign brownoutSleepOff = st.brownout_sleep_off;
   assign brownoutEnable = st.bodEnable;
   assign comparatorPowerDown = st.compPd;
   assign adcStartConv = st.adcStart;
   assign cpuClockEn = st.clkEn[smc_pkg::CLK_CPU];
   assign flashClockEn = st.clkEn[smc_pkg::CLK_FLASH];
   assign ioClockEn = st.clkEn[smc_pkg::CLK_IO];
   assign converterClockEn = st.clkEn[smc_pkg::CLK_ADC];
   assign asyncClockEn = st.clkEn[smc_pkg::CLK_ASY];
   assign mainOscEn = st.clkEn[smc_pkg::CLK_OSC];
   assign timerOscEn = st.clkEn[smc_pkg::CLK_TOSC];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // unarmed sleep check
   ignore_unarmed_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_RUN && sleepInstr && !sleepArmBit)
      |=> (sleepIgnored && !sleepActive && !cpuHalt))
      else $error("unarmed sleep was not ignored");
   armed_entry_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(st.fsm == smc_pkg::ST_SLEEP) |-> ($past(sleepInstr) && $past(sleepArmBit)))
      else $error("sleep entered without armed sleep instruction");
   idle_clocks_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_SLEEP && st.mode == smc_pkg::MODE_IDLE)
      |-> (!cpuClockEn && !flashClockEn && ioClockEn && converterClockEn))
      else $error("idle clock gating wrong");
   adcnr_clocks_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_SLEEP && st.mode == smc_pkg::MODE_ADCNR)
      |-> (!cpuClockEn && !flashClockEn && !ioClockEn && converterClockEn))
      else $error("noise reduction clock gating wrong");
   pdown_clocks_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_SLEEP && st.mode == smc_pkg::MODE_PDOWN)
      |-> (st.clkEn == smc_pkg::CLK_ALL_OFF))
      else $error("power-down left a clock running");
   adc_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_RUN && sleepInstr && sleepArmBit && adcEnabled &&
       sleepModeSelect == smc_pkg::MODE_ADCNR)
      |=> (adcStartConv && sleepActive) ##1 !adcStartConv)
      else $error("conversion not started on noise reduction entry");
   bod_shallow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_SLEEP && !deepMode(st.mode))
      |-> (brownoutEnable == $past(bodFuseEnable)))
      else $error("detector disabled in shallow mode");
   bod_off_entry_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_RUN && sleepInstr && sleepArmBit && st.brownout_sleep_off &&
       sleepModeSelect == smc_pkg::MODE_PDOWN)
      |=> !brownoutEnable)
      else $error("detector still on after entry");
   bod_wake_on_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_SLEEP && (wk.wakeIrq || wk.wakeReset))
      |=> (brownoutEnable == $past(bodFuseEnable)))
      else $error("detector not re-enabled on wake");
   bod_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st.fsm == smc_pkg::ST_SLEEP && st.bodOff && (wk.wakeIrq || wk.wakeReset))
      |=> (st.cnt == smc_pkg::CNT_W'(smc_pkg::BOD_WAKE_CYC)))
      else $error("wake delay after detector off wrong");
   halt_four_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(st.fsm == smc_pkg::ST_HALT) ##0 (!wk.wakeReset) [*4]
      |-> cpuHalt ##1 (irqResume && !cpuHalt))
      else $error("halt after wake not four cycles");
   reset_target_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      resetVector |-> (!irqResume && !cpuHalt && $past(st.resetWake || wk.wakeReset)))
      else $error("reset vector without reset source");
endmodule // smc_sleep_ctrl
`default_nettype wire

// *** smc_cpu_model.sv ***
/* cpu core model: sleep instruction and timed sleep-off write.
   assumes tasks are called just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module smc_cpu_model (
   // clock
   input wire logic sys_clk,
   // cpu side
   output logic sleepInstr,
   output logic bodsWrite,
   output logic bodsWrData,
   output logic bodsTimedEnable
);
   initial {sleepInstr, bodsWrite, bodsWrData, bodsTimedEnable} = 4'h0;
   task automatic exec_sleep();
      sleepInstr = 1'b1;
      @(posedge sys_clk) #1;
      sleepInstr = 1'b0;
   endtask
   task automatic put_brownout_sleep_off(input logic d, input logic en);
      {bodsWrite, bodsWrData, bodsTimedEnable} = {1'b1, d, en};
      @(posedge sys_clk) #1;
      {bodsWrite, bodsWrData, bodsTimedEnable} = {1'b0, ~d, 1'b0};
   endtask
endmodule // smc_cpu_model
`default_nettype wire

// *** tb_smc_sleep_ctrl.sv ***
/* self-checking bench of the sleep mode controller.
   assumes the cpu model and a 50 ns clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_smc_sleep_ctrl;
   logic sys_clk, reset_n, sleepArmBit, adcEnabled, comparatorDisableBit, bodFuseEnable;
   logic [2:0] sleepModeSelect, rst;
   logic [11:0] src;
   logic sleepInstr, bodsWrite, bodsWrData, bodsTimedEnable, cpuHalt, irqResume, resetVector;
   logic sleepIgnored, sleepActive, brownoutSleepOff, brownoutEnable, comparatorPowerDown;
   logic adcStartConv;
   logic [6:0] clkEn;
   int miscompares = 0, n_compared = 0, cycles = 0;
   smc_cpu_model smc_cpu_model_inst (.sys_clk, .sleepInstr, .bodsWrite, .bodsWrData,
      .bodsTimedEnable);
   smc_sleep_ctrl #(.STARTUP_CYCLES(2)) smc_sleep_ctrl_inst (.sys_clk, .reset_n, .sleepInstr,
      .cpuHalt, .irqResume, .resetVector, .sleepIgnored, .sleepActive, .sleepArmBit,
      .sleepModeSelect, .bodFuseEnable, .bodsWrite, .bodsWrData, .bodsTimedEnable,
      .brownoutSleepOff, .brownoutEnable, .comparatorDisableBit, .comparatorPowerDown,
      .adcEnabled, .adcDone(src[11]), .adcStartConv, .extIrqA(src[0]), .extIrqB(src[1]),
      .extLevelA(src[2]), .extLevelB(src[3]), .pinChangeIrq(src[4]), .twoWireMatch(src[5]),
      .timer2Irq(src[6]), .timer2Async(src[7]), .spmReady(src[8]), .watchdogIrq(src[9]),
      .otherIoIrq(src[10]), .extReset(rst[0]), .watchdogReset(rst[1]),
      .brownoutReset(rst[2]), .cpuClockEn(clkEn[6]), .flashClockEn(clkEn[5]),
      .ioClockEn(clkEn[4]), .converterClockEn(clkEn[3]), .asyncClockEn(clkEn[2]),
      .mainOscEn(clkEn[1]), .timerOscEn(clkEn[0]));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic enter(input logic [2:0] m, input logic [6:0] ck, input logic brownout_detector);
      sleepModeSelect = m;
      sleepArmBit = 1'b1;
      smc_cpu_model_inst.exec_sleep();
      chk("active", sleepActive, 1'b1);
      chk("halt", cpuHalt, 1'b1);
      chk("clocks", clkEn, ck);
      chk("bod", brownoutEnable, brownout_detector);
      chk("conv", adcStartConv, adcEnabled & (m == 3'h1));
   endtask
   task automatic wake(input logic [11:0] s, input logic [2:0] r, input logic [15:0] d);
      logic [15:0] n;
      n = 16'h0000;
      src = s;
      rst = r;
      do begin
         @(posedge sys_clk) #1;
         n++;
      end while (irqResume !== 1'b1 && resetVector !== 1'b1 && n < 16'h07D0);
      chk("delay", n, d);
      chk("reset", resetVector, |r);
      chk("resume", irqResume, ~|r);
      chk("run", cpuHalt, 1'b0);
      chk("bod on", brownoutEnable, bodFuseEnable);
      src = 12'h000;
      rst = 3'h0;
   endtask
   task automatic t_ignore();
      sleepModeSelect = 3'h2;
      smc_cpu_model_inst.exec_sleep();
      chk("ignored", sleepIgnored, 1'b1);
      chk("stay up", sleepActive, 1'b0);
      @(posedge sys_clk) #1;
      sleepArmBit = 1'b1;
      sleepModeSelect = 3'h5;
      smc_cpu_model_inst.exec_sleep();
      chk("reserved", sleepIgnored, 1'b1);
      $display("test ignore done");
   endtask
   task automatic t_idle();
      comparatorDisableBit = 1'b1;
      @(posedge sys_clk) #1;
      chk("cmp off", comparatorPowerDown, 1'b1);
      smc_cpu_model_inst.put_brownout_sleep_off(1'b1, 1'b1);
      for (int i = 0; i < 12; i++) begin
         if (i inside {2, 3, 7}) continue;
         enter(3'h0, 7'h1E, 1'b1);
         wake(12'h001 << i, 3'h0, 16'h000B);
      end
      comparatorDisableBit = 1'b0;
      $display("test idle done");
   endtask
   task automatic t_noise();
      adcEnabled = 1'b1;
      enter(3'h1, 7'h0A, 1'b1);
      chk("cmp on", comparatorPowerDown, 1'b0);
      wake(12'h800, 3'h0, 16'h000B);
      adcEnabled = 1'b0;
      $display("test noise done");
   endtask
   task automatic t_pdown();
      smc_cpu_model_inst.put_brownout_sleep_off(1'b0, 1'b0);
      chk("refused", brownoutSleepOff, 1'b1);
      enter(3'h2, 7'h00, 1'b0);
      src = 12'h041;
      repeat (3) @(posedge sys_clk) #1;
      chk("edge irq", sleepActive, 1'b1);
      chk("cmp auto", comparatorPowerDown, 1'b1);
      wake(12'h005, 3'h0, 16'h04B5);
      $display("test pdown done");
   endtask
   task automatic t_deep();
      smc_cpu_model_inst.put_brownout_sleep_off(1'b0, 1'b1);
      chk("brownout_sleep_off 0", brownoutSleepOff, 1'b0);
      src = 12'h080;
      enter(3'h3, 7'h05, 1'b1);
      wake(12'h0C0, 3'h0, 16'h0007);
      // standby only with a crystal clock
      for (int i = 0; i < 3; i++) begin
         enter(3'h6, 7'h02, 1'b1);
         wake(12'h000, 3'h1 << i, 16'h0007);
      end
      enter(3'h7, 7'h02, 1'b1);
      wake(12'h010, 3'h0, 16'h000B);
      bodFuseEnable = 1'b0;
      enter(3'h7, 7'h02, 1'b0);
      wake(12'h010, 3'h0, 16'h000B);
      bodFuseEnable = 1'b1;
      $display("test deep done");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      {reset_n, sleepArmBit, adcEnabled, comparatorDisableBit} = 4'h0;
      bodFuseEnable = 1'b1;
      sleepModeSelect = 3'h0;
      rst = 3'h0;
      src = 12'h000;
      repeat (4) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      chk("rst clk", clkEn, 7'h7F);
      chk("rst brownout_sleep_off", brownoutSleepOff, 1'b0);
      t_ignore();
      t_idle();
      t_noise();
      t_pdown();
      t_deep();
      print_verdict();
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         print_verdict();
      end
   end
endmodule // tb_smc_sleep_ctrl
`default_nettype wire
